// ==== shunt_pwm_pkg.sv ====
/*
  Shared constants and carrier types for the single-shunt PWM generator.
  Assumes a 50 MHz system clock; every cycle count is derived from it here.
*/
`default_nettype none

package shunt_pwm_pkg;

  // ********************************************************************
  // Clock and timing figures
  // ********************************************************************
  localparam int CLK_MHZ = 50;
  localparam int PWM_PERIOD_NS = 62500;
  localparam int TRIG_GAP_NS = 3000;
  localparam int VEC_MIN_NS = 2500;

  // Period rounds down, least times round up to whole cycles.
  localparam logic [11:0] PERIOD_CYC = 12'((PWM_PERIOD_NS * CLK_MHZ) / 1000);
  localparam logic [11:0] LAST_CYC = 12'(PERIOD_CYC - 12'h001);
  localparam logic [11:0] CENTRE_CYC = 12'(PERIOD_CYC >> 1);
  localparam logic [11:0] TRIG_GAP_CYC = 12'((TRIG_GAP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] VEC_MIN_CYC = 12'((VEC_MIN_NS * CLK_MHZ + 999) / 1000);

  // ********************************************************************
  // Switching state codes, high-side of A, B, C from bit 2 down to 0; last result index
  // ********************************************************************
  localparam logic [2:0] VEC_ZERO = 3'h0;
  localparam logic [2:0] VEC_ALL_HIGH = 3'h7;
  localparam logic [2:0] RES_LAST = 3'h2;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef logic [2:0][11:0] duty_t;

  typedef enum logic [1:0] {TRIG_CUR1, TRIG_CUR2, TRIG_ZERO, TRIG_DONE} trig_stage_e;

  typedef struct packed {
    logic [7:0] dead_cyc;
    logic [7:0] prop_cyc;
    logic [11:0] vec_min_cyc;
  } timing_cfg_s;

  typedef struct packed {
    logic sector_border;
    logic low_mod;
    logic no_shift;
  } sense_flags_s;

  typedef struct packed {
    logic [11:0] cur1;
    logic [11:0] cur2;
    logic [11:0] zero_ref;
    logic [2:0] vec1;
    logic [2:0] vec2;
  } samples_s;

endpackage

`default_nettype wire

// ==== single_shunt_pwm_adc_trigger.sv ====
/*
  Three-phase centre-aligned PWM generator with ADC trigger scheduling for
  single-shunt DC-link current sensing, with asymmetric edge shifting.
  Assumes duty commands, timing settings and ADC results are synchronous to
  sys_clk, and that ADC results return in the order the triggers were sent.
*/
// Contract
// - Three ADC triggers every second PWM period, none in the other periods.
// - First two triggers sample DC-link current in two distinct active vectors.
// - Each current trigger sits at the midpoint of its active vector, or at its start plus the switching delay if that is later.
// - Third trigger sits at the period midpoint, all high sides on.
// - Third sample is published as the zero-current offset reference.
// - Detect sector-border crossing where only one vector is long enough.
// - Detect low modulation where both vectors are too short.
// - Edge shifting never changes any phase duty cycle.
// - Sector-border case keeps centre fixed, moves only one critical pulse.
// - Low-modulation case moves two pulses in opposite directions.
// - Consecutive triggers at least 3 us apart.
// - Active vector at least about 2.5 us before sampling, configurable; vectors stretch to vec_min, sampled at the midpoint, about half that.
// - Duty is limited so the minimum edge shift always fits.
// - No asymmetric shifting when any phase is commanded to full duty.
// - 62.5 us period; sampling and reload every 125 us.
`timescale 1ns/1ns
`default_nettype none

module single_shunt_pwm_adc_trigger
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire shunt_pwm_pkg::duty_t duty_cmd,
  input wire shunt_pwm_pkg::timing_cfg_s timing_cfg,
  input wire logic adc_done,
  input wire logic [11:0] adc_result,
  output logic [2:0] pwm_hi,
  output logic reload_pulse,
  output logic adc_trig,
  output shunt_pwm_pkg::trig_stage_e trig_stage,
  output logic [2:0] trig_vector,
  output shunt_pwm_pkg::sense_flags_s sense_flags,
  output shunt_pwm_pkg::samples_s samples,
  output logic samples_valid
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [11:0] cnt;
    logic odd;
    shunt_pwm_pkg::duty_t duty;
    logic no_shift;
    shunt_pwm_pkg::trig_stage_e stage;
    logic [11:0] since_last;
    logic [2:0] res_idx;
    logic [2:0] pwm_hi;
    logic reload_pulse;
    logic adc_trig;
    shunt_pwm_pkg::trig_stage_e trig_stage;
    logic [2:0] trig_vector;
    shunt_pwm_pkg::sense_flags_s flags;
    shunt_pwm_pkg::samples_s samples;
    logic samples_valid;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Effective minimum vector length and trigger delay.
  logic [11:0] vec_min, trig_dly, duty_lim;
  // Phase ordering by duty.
  logic [1:0] imax, imid, imin;
  logic [11:0] v1_len, v2_len, shift1, shift2;
  logic short1, short2;
  logic [2:0][11:0] rise, fall;
  logic [11:0] v1_start, v1_end, v2_start, v2_end;
  logic [11:0] v1_mid, v2_mid, t_cur1, t_cur2, t_now;
  logic [2:0] vec1, vec2;
  logic sampling, fire, full_cmd;

  // ********************************************************************
  // Duty limit and phase ordering
  // ********************************************************************
  // A configured minimum below the nominal figure is raised to it.
  always_comb
  begin
    vec_min = (timing_cfg.vec_min_cyc > shunt_pwm_pkg::VEC_MIN_CYC) ?
              timing_cfg.vec_min_cyc : shunt_pwm_pkg::VEC_MIN_CYC;
    trig_dly = 12'(timing_cfg.dead_cyc) + 12'(timing_cfg.prop_cyc);
    duty_lim = 12'(shunt_pwm_pkg::PERIOD_CYC - (vec_min << 1));
    full_cmd = (duty_cmd[0] >= shunt_pwm_pkg::PERIOD_CYC) ||
               (duty_cmd[1] >= shunt_pwm_pkg::PERIOD_CYC) ||
               (duty_cmd[2] >= shunt_pwm_pkg::PERIOD_CYC);
    sampling = !state_reg.odd;
  end

  // Index 2 is phase A, index 0 is phase C; ties resolve to distinct indices.
  always_comb
  begin
    if (state_reg.duty[0] >= state_reg.duty[1] && state_reg.duty[0] >= state_reg.duty[2])
      imax = 2'd0;
    else if (state_reg.duty[1] >= state_reg.duty[2])
      imax = 2'd1;
    else
      imax = 2'd2;
    if (state_reg.duty[2] <= state_reg.duty[1] && state_reg.duty[2] <= state_reg.duty[0])
      imin = 2'd2;
    else if (state_reg.duty[1] <= state_reg.duty[0])
      imin = 2'd1;
    else
      imin = 2'd0;
    imid = 2'(2'd3 - imax - imin);
  end

  // ********************************************************************
  // Vector lengths, shortness detection and edge shifts
  // ********************************************************************
  // Shifting a whole pulse moves both its edges together, so duty holds.
  always_comb
  begin
    v1_len = 12'((state_reg.duty[imax] - state_reg.duty[imid]) >> 1);
    v2_len = 12'((state_reg.duty[imid] - state_reg.duty[imin]) >> 1);
    short1 = v1_len < vec_min;
    short2 = v2_len < vec_min;
    shift1 = (short1 && !state_reg.no_shift && sampling) ? 12'(vec_min - v1_len) : 12'h000;
    shift2 = (short2 && !state_reg.no_shift && sampling) ? 12'(vec_min - v2_len) : 12'h000;
    for (int i = 0; i < 3; i++)
    begin
      rise[i] = 12'(shunt_pwm_pkg::CENTRE_CYC - (state_reg.duty[i] >> 1));
      fall[i] = 12'(rise[i] + state_reg.duty[i]);
    end
    // Largest pulse moves earlier, smallest later: opposite directions.
    rise[imax] = 12'(rise[imax] - shift1);
    fall[imax] = 12'(fall[imax] - shift1);
    rise[imin] = 12'(rise[imin] + shift2);
    fall[imin] = 12'(fall[imin] + shift2);
  end

  // ********************************************************************
  // Trigger placement
  // ********************************************************************
  // Builds a switching state with the high-side bits of up to two phases set.
  function automatic logic [2:0] vec_of_phases(input logic [1:0] a, input logic [1:0] b);
    logic [2:0] v;
    v = shunt_pwm_pkg::VEC_ZERO;
    v[a] = 1'b1;
    if (b != 2'd3)
      v[b] = 1'b1;
    return v;
  endfunction

  // Each current trigger is the vector midpoint, held off by the delay.
  always_comb
  begin
    v1_start = rise[imax];
    v1_end = rise[imid];
    v2_start = rise[imid];
    v2_end = rise[imin];
    v1_mid = 12'((13'(v1_start) + 13'(v1_end)) >> 1);
    v2_mid = 12'((13'(v2_start) + 13'(v2_end)) >> 1);
    t_cur1 = (v1_mid > 12'(v1_start + trig_dly)) ? v1_mid : 12'(v1_start + trig_dly);
    t_cur2 = (v2_mid > 12'(v2_start + trig_dly)) ? v2_mid : 12'(v2_start + trig_dly);
    vec1 = vec_of_phases(imax, 2'd3);
    vec2 = vec_of_phases(imax, imid);
    case (state_reg.stage)
      shunt_pwm_pkg::TRIG_CUR1: t_now = t_cur1;
      shunt_pwm_pkg::TRIG_CUR2: t_now = t_cur2;
      shunt_pwm_pkg::TRIG_ZERO: t_now = shunt_pwm_pkg::CENTRE_CYC;
      default: t_now = shunt_pwm_pkg::LAST_CYC;
    endcase
    fire = sampling && (state_reg.stage != shunt_pwm_pkg::TRIG_DONE) &&
           (state_reg.cnt >= t_now) &&
           (state_reg.since_last >= shunt_pwm_pkg::TRIG_GAP_CYC);
  end

  // ********************************************************************
  // Next state
  // ********************************************************************
  // Counter, reload, trigger sequencing and ADC result collection.
  always_comb
  begin
    state_next = state_reg;
    state_next.reload_pulse = 1'b0;
    state_next.adc_trig = 1'b0;
    state_next.samples_valid = 1'b0;
    // Period counter; the even period is the sampling period.
    if (state_reg.cnt == shunt_pwm_pkg::LAST_CYC)
    begin
      state_next.cnt = 12'h000;
      state_next.odd = !state_reg.odd;
      state_next.stage = shunt_pwm_pkg::TRIG_DONE;
      if (state_reg.odd)
      begin
        // Reload every second period: new duties, clamped to the limit.
        state_next.reload_pulse = 1'b1;
        state_next.stage = shunt_pwm_pkg::TRIG_CUR1;
        state_next.res_idx = 3'h0;
        state_next.no_shift = full_cmd;
        for (int i = 0; i < 3; i++)
          state_next.duty[i] = (duty_cmd[i] > duty_lim) ? duty_lim : duty_cmd[i];
      end
    end
    else
      state_next.cnt = 12'(state_reg.cnt + 12'h001);
    // Gap counter saturates so the first trigger is never held off.
    if (fire)
      state_next.since_last = 12'h000;
    else if (state_reg.since_last < shunt_pwm_pkg::TRIG_GAP_CYC)
      state_next.since_last = 12'(state_reg.since_last + 12'h001);
    // Trigger issue and stage advance.
    if (fire)
    begin
      state_next.adc_trig = 1'b1;
      state_next.trig_stage = state_reg.stage;
      case (state_reg.stage)
        shunt_pwm_pkg::TRIG_CUR1:
        begin
          state_next.trig_vector = vec1;
          state_next.samples.vec1 = vec1;
          state_next.stage = shunt_pwm_pkg::TRIG_CUR2;
        end
        shunt_pwm_pkg::TRIG_CUR2:
        begin
          state_next.trig_vector = vec2;
          state_next.samples.vec2 = vec2;
          state_next.stage = shunt_pwm_pkg::TRIG_ZERO;
        end
        default:
        begin
          state_next.trig_vector = shunt_pwm_pkg::VEC_ALL_HIGH;
          state_next.stage = shunt_pwm_pkg::TRIG_DONE;
        end
      endcase
    end
    // Sense flags are refreshed with each sampling period's first trigger.
    if (fire && state_reg.stage == shunt_pwm_pkg::TRIG_CUR1)
    begin
      state_next.flags.sector_border = short1 ^ short2;
      state_next.flags.low_mod = short1 && short2;
      state_next.flags.no_shift = state_reg.no_shift;
    end
    // Results return in trigger order; the third is the offset reference.
    if (adc_done && state_reg.res_idx <= shunt_pwm_pkg::RES_LAST)
    begin
      case (state_reg.res_idx)
        3'h0: state_next.samples.cur1 = adc_result;
        3'h1: state_next.samples.cur2 = adc_result;
        default:
        begin
          state_next.samples.zero_ref = adc_result;
          state_next.samples_valid = 1'b1;
        end
      endcase
      state_next.res_idx = 3'(state_reg.res_idx + 3'h1);
    end
    // High-side outputs follow the edge compare of the current count.
    for (int i = 0; i < 3; i++)
      state_next.pwm_hi[i] = (state_reg.cnt >= rise[i]) && (state_reg.cnt < fall[i]);
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  // Reset parks the counter so the first period after release samples.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.cnt <= shunt_pwm_pkg::LAST_CYC;
      state_reg.odd <= 1'b1;
      state_reg.stage <= shunt_pwm_pkg::TRIG_DONE;
      state_reg.since_last <= shunt_pwm_pkg::TRIG_GAP_CYC;
      state_reg.res_idx <= 3'h3;
      state_reg.trig_stage <= shunt_pwm_pkg::TRIG_DONE;
    end
    else
      state_reg <= state_next;
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // All outputs come straight from the state register.
  assign pwm_hi = state_reg.pwm_hi;
  assign reload_pulse = state_reg.reload_pulse;
  assign adc_trig = state_reg.adc_trig;
  assign trig_stage = state_reg.trig_stage;
  assign trig_vector = state_reg.trig_vector;
  assign sense_flags = state_reg.flags;
  assign samples = state_reg.samples;
  assign samples_valid = state_reg.samples_valid;

endmodule // single_shunt_pwm_adc_trigger

`default_nettype wire

// ==== shunt_pwm_checker.sv ====
/*
  Port assertions for the single-shunt PWM block.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ns
`default_nettype none

module shunt_pwm_checker
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic adc_done,
  input wire logic [11:0] adc_result,
  input wire logic [2:0] pwm_hi,
  input wire logic reload_pulse,
  input wire logic adc_trig,
  input wire shunt_pwm_pkg::trig_stage_e trig_stage,
  input wire logic [2:0] trig_vector,
  input wire shunt_pwm_pkg::sense_flags_s sense_flags,
  input wire shunt_pwm_pkg::samples_s samples,
  input wire logic samples_valid
);
  logic [12:0] since_reload;
  logic [7:0] since_trig;
  logic [1:0] trig_cnt;
  logic seen_reload;

  // Counts cycles since reload and since trigger, and triggers per reload interval.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      since_reload <= 13'h0000;
      since_trig <= 8'hFF;
      trig_cnt <= 2'h0;
      seen_reload <= 1'b0;
    end
    else
    begin
      since_reload <= reload_pulse ? 13'h0000 : since_reload + 13'h0001;
      since_trig <= adc_trig ? 8'h00 : (since_trig == 8'hFF ? 8'hFF : since_trig + 8'h01);
      trig_cnt <= reload_pulse ? 2'h0 : (adc_trig ? trig_cnt + 2'h1 : trig_cnt);
      seen_reload <= seen_reload | reload_pulse;
    end
  end

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_reload_period;
    reload_pulse && seen_reload |-> since_reload == 13'h1869;
  endproperty
  a_reload_period: assert property (p_reload_period) else $error("reload spacing");
  property p_three_triggers;
    reload_pulse && seen_reload |-> trig_cnt == 2'h3;
  endproperty
  a_three_triggers: assert property (p_three_triggers) else $error("trigger count");
  property p_quiet_period;
    adc_trig |-> seen_reload && since_reload < 13'h0C34;
  endproperty
  a_quiet_period: assert property (p_quiet_period) else $error("trigger off period");
  property p_trigger_gap;
    adc_trig |-> since_trig >= 8'h95;
  endproperty
  a_trigger_gap: assert property (p_trigger_gap) else $error("trigger gap");
  property p_stage_order;
    adc_trig |=> trig_stage == shunt_pwm_pkg::trig_stage_e'(trig_cnt - 2'h1);
  endproperty
  a_stage_order: assert property (p_stage_order) else $error("trigger order");
  property p_zero_slot;
    adc_trig && trig_cnt == 2'h2 |-> since_reload >= 13'h061A
      ##1 trig_vector == shunt_pwm_pkg::VEC_ALL_HIGH;
  endproperty
  a_zero_slot: assert property (p_zero_slot) else $error("zero trigger slot");
  property p_vec_weight;
    adc_trig && trig_cnt < 2'h2 |=> $countones(trig_vector) == 32'(trig_cnt);
  endproperty
  a_vec_weight: assert property (p_vec_weight) else $error("sampled vector");
  property p_zero_result;
    samples_valid |-> ($past(adc_done) && samples.zero_ref == $past(adc_result))
      ##1 !samples_valid;
  endproperty
  a_zero_result: assert property (p_zero_result) else $error("zero reference");
  property p_idle_low;
    reload_pulse |-> pwm_hi == shunt_pwm_pkg::VEC_ZERO;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("gates high at reload");

  c_valid: cover property (samples_valid);
  c_border: cover property ($rose(sense_flags.sector_border));
  c_low: cover property ($rose(sense_flags.low_mod));
endmodule // shunt_pwm_checker

`default_nettype wire

// ==== adc_model.sv ====
/*
  Behavioural ADC: converts on each trigger and answers after lat_cyc cycles.
  Assumes one conversion outstanding at a time and lat_cyc of one or more.
*/
`timescale 1ns/1ns
`default_nettype none

module adc_model
(
  input wire logic sys_clk,
  input wire logic adc_trig,
  input wire logic [2:0] pwm_hi,
  input wire logic [7:0] lat_cyc,
  output logic adc_done = 1'b0,
  output logic [11:0] adc_result = 12'h000
);
  logic [7:0] left = 8'h00;
  logic [11:0] held;

  // Holds the gate state at the trigger; the bus toggles while no result stands.
  always @(posedge sys_clk)
  begin
    adc_done <= 1'b0;
    adc_result <= ~adc_result;
    if (adc_trig)
    begin
      held <= {1'h0, pwm_hi, 8'h5A};
      left <= lat_cyc;
    end
    else if (left != 8'h00)
      left <= left - 8'h01;
    if (!adc_trig && left == 8'h01)
    begin
      adc_done <= 1'b1;
      adc_result <= held;
    end
  end
endmodule // adc_model

`default_nettype wire

// ==== single_shunt_pwm_adc_trigger_test.sv ====
/*
  Self-checking bench for the single-shunt PWM block and its ADC model.
  Assumes the package, checker and ADC model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module single_shunt_pwm_adc_trigger_test;
  logic sys_clk, rst, adc_done, adc_trig, reload_pulse, samples_valid;
  logic [11:0] adc_result;
  logic [2:0] pwm_hi, trig_vector;
  logic [7:0] lat_cyc;
  shunt_pwm_pkg::duty_t duty_cmd;
  shunt_pwm_pkg::timing_cfg_s timing_cfg;
  shunt_pwm_pkg::trig_stage_e trig_stage;
  shunt_pwm_pkg::sense_flags_s sense_flags;
  shunt_pwm_pkg::samples_s samples;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int on_cnt[3];
  int trig_at[3];
  int n_trig;

  single_shunt_pwm_adc_trigger DUT (.sys_clk, .rst, .duty_cmd, .timing_cfg, .adc_done,
    .adc_result, .pwm_hi, .reload_pulse, .adc_trig, .trig_stage, .trig_vector,
    .sense_flags, .samples, .samples_valid);
  adc_model u_adc (.sys_clk, .adc_trig, .pwm_hi, .lat_cyc, .adc_done, .adc_result);

  // Makes the 50 MHz clock.
  always #10 sys_clk = ~sys_clk;

  // Cuts a hang short at 40000 cycles, some 12000 more than the scenarios need.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  task automatic wait_reload();
    do
      @(negedge sys_clk);
    while (reload_pulse !== 1'b1);
  endtask

  // Applies a command, then records on-times and trigger cycles of one sampling period.
  task automatic run(input logic [11:0] a, b, c, input logic [7:0] dead, prop,
    input logic [11:0] vmin, input logic [7:0] lat);
    @(posedge sys_clk);
    duty_cmd <= {a, b, c};
    timing_cfg <= {dead, prop, vmin};
    lat_cyc <= lat;
    wait_reload();
    on_cnt = '{0, 0, 0};
    n_trig = 0;
    for (int k = 1; k <= 3125; k++)
    begin
      @(negedge sys_clk);
      for (int i = 0; i < 3; i++)
        on_cnt[i] += int'(pwm_hi[i]);
      if (adc_trig === 1'b1)
      begin
        if (n_trig < 3)
          trig_at[n_trig] = k;
        n_trig++;
      end
    end
  endtask

  // Judges on-times, trigger count and the results paired with each trigger.
  task automatic check_period(input logic [11:0] a, b, c, input logic [2:0] v1, v2);
    check("duty A", a, 12'(on_cnt[2]));
    check("duty B", b, 12'(on_cnt[1]));
    check("duty C", c, 12'(on_cnt[0]));
    check("triggers", 12'h003, 12'(n_trig));
    check("vec1", {9'h000, v1}, {9'h000, samples.vec1});
    check("vec2", {9'h000, v2}, {9'h000, samples.vec2});
    check("cur1", {1'h0, v1, 8'h5A}, samples.cur1);
    check("cur2", {1'h0, v2, 8'h5A}, samples.cur2);
    check("zero", 12'h75A, samples.zero_ref);
  endtask

  // Equal duties leave no vector, so two pulses move apart; the gap then rules.
  task automatic test_low_mod();
    run(12'h3E8, 12'h3E8, 12'h3E8, 8'h0A, 8'h0A, 12'h000, 8'h02);
    check_period(12'h3E8, 12'h3E8, 12'h3E8, 3'h1, 3'h3);
    check("flags", 12'h002, {9'h000, sense_flags});
    check("gap", 12'h097, 12'(trig_at[1] - trig_at[0]));
    $display("test low_mod done");
  endtask

  // Two close duties: only the longest pulse moves; the ADC answers slowly.
  task automatic test_sector();
    run(12'h1F4, 12'h7D0, 12'h76C, 8'h0A, 8'h0A, 12'h0C8, 8'h78);
    check_period(12'h1F4, 12'h7D0, 12'h76C, 3'h2, 3'h3);
    check("flags", 12'h004, {9'h000, sense_flags});
    check("trig1", 12'h201, 12'(trig_at[0]));
    $display("test sector done");
  endtask

  // Wide vectors with a long switching delay push the first trigger late.
  task automatic test_wide();
    run(12'h9C4, 12'h5DC, 12'h1F4, 8'hC8, 8'h64, 12'h000, 8'h02);
    check_period(12'h9C4, 12'h5DC, 12'h1F4, 3'h4, 3'h6);
    check("flags", 12'h000, {9'h000, sense_flags});
    check("trig1", 12'h265, 12'(trig_at[0]));
    check("trig2", 12'h459, 12'(trig_at[1]));
    check("trig3", 12'h61B, 12'(trig_at[2]));
    $display("test wide done");
  endtask

  // A full-duty command is limited and turns shifting off.
  task automatic test_full();
    run(12'hC35, 12'h3E8, 12'h3E8, 8'h0A, 8'h0A, 12'h000, 8'h02);
    check("no shift", 12'h001, {11'h000, sense_flags.no_shift});
    check("duty A", 12'hB3B, 12'(on_cnt[2]));
    check("duty C", 12'h3E8, 12'(on_cnt[0]));
    $display("test full done");
  endtask

  // Resets the block, lets the first reload pass and runs each scenario.
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    duty_cmd = '0;
    timing_cfg = '0;
    lat_cyc = 8'h02;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    wait_reload();
    test_low_mod();
    test_sector();
    test_wide();
    test_full();
    end_of_test();
  end
endmodule // single_shunt_pwm_adc_trigger_test

bind single_shunt_pwm_adc_trigger shunt_pwm_checker chk (.sys_clk, .rst, .adc_done,
  .adc_result, .pwm_hi, .reload_pulse, .adc_trig, .trig_stage, .trig_vector,
  .sense_flags, .samples, .samples_valid);

`default_nettype wire
